// [verilog/gpio_pin_pwm_control.sv]
`timescale 1ns/1ns
`include "gpio_pwm_regs.svh"

// Function
// - a per-pin select bit gives the pin to GPIO when set, serial port when clear.
// - the direction bit makes the pin an output at 1 and an input at 0.
// - outputs are driven push-pull, open-drain or tri-state as selected.
// - a plain output without pulse control drives its level bit.
// - idle pulse mode keeps the pulse output quiet with no toggling.
// - stop-low holds the pin low and stop-high holds it high while idle.
// - one-shot drives the opposite level for one generator cycle, then stops.
// - a finished one-shot returns the pin's mode to idle by itself.
// - run mode toggles the pin continuously from the chosen generator.
// - each pin picks generator A, B, or none which disables pulse mode.
// - a GPIO pin without pulse control reports its real level in status.
module gpio_pin_pwm_control
	import gpio_pwm_pkg::*;
#(
	parameter int NPINS = 8,
	parameter int CW    = 16
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [NPINS-1:0] pinIn,
	output logic      [NPINS-1:0] pinOut,
	output logic      [NPINS-1:0] pinOe,
	output logic      [NPINS-1:0] gpioOwned,
	input  wire logic [NPINS-1:0] serialOut,
	input  wire logic [NPINS-1:0] serialOe,
	output logic      [NPINS-1:0] serialIn
);

	logic [NPINS-1:0]            pinMeta_r;
	logic [NPINS-1:0]            pinSync_r;
	logic [`CFG_WIDTH-1:0]       cfg_r [NPINS];
	logic [CW-1:0]               per_r [2];
	logic [CW-1:0]               low_r [2];
	logic [1:0]                  wave;
	logic [1:0]                  perEnd;
	logic [NPINS-1:0]            shotDone;
	logic [NPINS-1:0]            pulseLvl;
	logic [NPINS-1:0]            pulseOn;
	logic [NPINS-1:0]            shotArm_r;
	logic [NPINS-1:0]            shotLvl_r;
	logic                        wrEn;
	logic                        rdEn;
	logic                        cfgHit;
	logic [11:0]                 cfgIdx;
	logic [31:0]                 rdData;
	logic                        rdErr;

	assign wrEn   = psel && penable && pwrite;
	assign rdEn   = psel && penable && !pwrite;
	assign cfgIdx = {2'h0, paddr[11:2]};
	assign cfgHit = (paddr < `PINSTAT_OFF) && (paddr[1:0] == 2'h0)
		&& (cfgIdx < 12'(NPINS));

	always_ff @(posedge clk) begin
		if (srst) begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
		end else begin
			pinMeta_r <= pinIn;
			pinSync_r <= pinMeta_r;
		end
	end

	generate
		for (genvar g = 0; g < 2; g++) begin : gen_pg
			always_ff @(posedge clk) begin
				if (srst) begin
					per_r[g] <= CW'(`PER_RESET);
					low_r[g] <= CW'(`LOW_RESET);
				end else if (wrEn && paddr == (g == 0 ? `PWMPER0_OFF
						: `PWMPER1_OFF)) begin
					per_r[g] <= pwdata[CW-1:0];
				end else if (wrEn && paddr == (g == 0 ? `PWMLOW0_OFF
						: `PWMLOW1_OFF)) begin
					low_r[g] <= pwdata[CW-1:0];
				end
			end

			pulse_gen #(.CW(CW)) u_gen (
				.clk       (clk),
				.srst      (srst),
				.period    (per_r[g]),
				.lowTime   (low_r[g]),
				.wave      (wave[g]),
				.periodEnd (perEnd[g])
			);
		end
	endgenerate

	generate
		for (genvar p = 0; p < NPINS; p++) begin : gen_pin
			logic        sel;
			logic        dirOut;
			drive_e      drv;
			logic        lvl;
			pulse_mode_e mode;
			gen_sel_e    gsel;
			logic        gWave;
			logic        gEnd;
			logic        drvLvl;
			logic        wrThis;

			assign sel    = cfg_r[p][`CFG_SEL_BIT];
			assign dirOut = cfg_r[p][`CFG_DIR_BIT];
			assign drv    = drive_e'(cfg_r[p][`CFG_TYPE_LSB +: 2]);
			assign lvl    = cfg_r[p][`CFG_LVL_BIT];
			assign mode   = pulse_mode_e'(cfg_r[p][`CFG_MODE_LSB +: 3]);
			assign gsel   = gen_sel_e'(cfg_r[p][`CFG_GEN_LSB +: 2]);
			assign gWave  = (gsel == GEN_B) ? wave[1] : wave[0];
			assign gEnd   = (gsel == GEN_B) ? perEnd[1] : perEnd[0];
			assign wrThis = wrEn && cfgHit && (cfgIdx == 12'(p));
			assign pulseOn[p] = (gsel == GEN_A) || (gsel == GEN_B);

			// one-shot arms on the next period start, runs one period
			assign shotDone[p] = pulseOn[p] && mode == PM_ONESHOT
				&& shotArm_r[p] && gEnd;

			always_ff @(posedge clk) begin
				if (srst) begin
					shotArm_r[p] <= 1'b0;
					shotLvl_r[p] <= 1'b0;
				end else if (!(pulseOn[p] && mode == PM_ONESHOT)) begin
					shotArm_r[p] <= 1'b0;
					shotLvl_r[p] <= lvl;
				end else if (gEnd) begin
					shotArm_r[p] <= 1'b1;
				end
			end

			// per-pin storage, only this pin's word and its one-shot end touch it
			always_ff @(posedge clk) begin
				if (srst) begin
					cfg_r[p] <= `CFG_RESET;
				end else begin
					if (wrThis) begin
						cfg_r[p] <= pwdata[`CFG_WIDTH-1:0];
					end
					if (shotDone[p]) begin
						cfg_r[p][`CFG_MODE_LSB +: 3] <= PM_IDLE;
					end
				end
			end

			always_comb begin
				pulseLvl[p] = lvl;
				if (pulseOn[p]) begin
					unique case (mode)
						PM_IDLE:     pulseLvl[p] = lvl;
						PM_STOPLOW:  pulseLvl[p] = 1'b0;
						PM_STOPHIGH: pulseLvl[p] = 1'b1;
						PM_RUN:      pulseLvl[p] = gWave;
						PM_ONESHOT:  pulseLvl[p] = shotArm_r[p]
							? !shotLvl_r[p] : shotLvl_r[p];
						default:     pulseLvl[p] = lvl;
					endcase
				end
			end

			assign drvLvl = pulseLvl[p];

			always_ff @(posedge clk) begin
				if (srst) begin
					pinOut[p]    <= 1'b0;
					pinOe[p]     <= 1'b0;
					gpioOwned[p] <= 1'b0;
					serialIn[p]  <= 1'b0;
				end else if (!sel) begin
					pinOut[p]    <= serialOut[p];
					pinOe[p]     <= serialOe[p];
					gpioOwned[p] <= 1'b0;
					serialIn[p]  <= pinSync_r[p];
				end else begin
					gpioOwned[p] <= 1'b1;
					serialIn[p]  <= 1'b1;
					if (!dirOut) begin
						pinOut[p] <= 1'b0;
						pinOe[p]  <= 1'b0;
					end else begin
						unique case (drv)
							DRV_OPENDRAIN: begin
								pinOut[p] <= 1'b0;
								pinOe[p]  <= !drvLvl;
							end
							DRV_TRISTATE: begin
								pinOut[p] <= drvLvl;
								pinOe[p]  <= 1'b0;
							end
							default: begin
								pinOut[p] <= drvLvl;
								pinOe[p]  <= 1'b1;
							end
						endcase
					end
				end
			end
		end
	endgenerate

	always_comb begin
		rdData = 32'h0000_0000;
		rdErr  = 1'b0;
		if (cfgHit) begin
			rdData[`CFG_WIDTH-1:0] = cfg_r[cfgIdx[$clog2(NPINS)-1:0]];
		end else if (paddr == `PINSTAT_OFF) begin
			for (int i = 0; i < NPINS; i++) begin
				rdData[i] = cfg_r[i][`CFG_SEL_BIT] && !pulseOn[i]
					&& pinSync_r[i];
			end
		end else if (paddr == `PWMPER0_OFF) begin
			rdData[CW-1:0] = per_r[0];
		end else if (paddr == `PWMPER1_OFF) begin
			rdData[CW-1:0] = per_r[1];
		end else if (paddr == `PWMLOW0_OFF) begin
			rdData[CW-1:0] = low_r[0];
		end else if (paddr == `PWMLOW1_OFF) begin
			rdData[CW-1:0] = low_r[1];
		end else begin
			rdErr = 1'b1;
		end
	end

	// zero-wait apb: ready is a flop raised in the access cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && rdErr;
			prdata  <= (psel && !penable && !pwrite) ? rdData : 32'h0000_0000;
		end
	end

	input_pin_a: assert property (@(posedge clk) disable iff (srst)
		!cfg_r[0][`CFG_SEL_BIT] ##1 (cfg_r[0][`CFG_SEL_BIT]
		&& !cfg_r[0][`CFG_DIR_BIT]) |=> !pinOe[0])
		else $error("input pin still driven");
	serial_own_a: assert property (@(posedge clk) disable iff (srst)
		!cfg_r[0][`CFG_SEL_BIT] |=> (pinOe[0] == $past(serialOe[0])
		&& !gpioOwned[0]))
		else $error("serial pin not passed through");
	plain_level_a: assert property (@(posedge clk) disable iff (srst)
		(cfg_r[0][`CFG_SEL_BIT] && cfg_r[0][`CFG_DIR_BIT]
		&& cfg_r[0][`CFG_TYPE_LSB +: 2] == 2'h0 && !pulseOn[0])
		|=> (pinOut[0] == $past(cfg_r[0][`CFG_LVL_BIT]) && pinOe[0]))
		else $error("plain output level wrong");
	open_drain_a: assert property (@(posedge clk) disable iff (srst)
		(cfg_r[0][`CFG_SEL_BIT] && cfg_r[0][`CFG_DIR_BIT]
		&& cfg_r[0][`CFG_TYPE_LSB +: 2] == 2'h1)
		|=> (!pinOut[0] && pinOe[0] == !$past(pulseLvl[0])))
		else $error("open drain drove high");
	stop_hold_a: assert property (@(posedge clk) disable iff (srst)
		(pulseOn[0] && cfg_r[0][`CFG_MODE_LSB +: 3] == 3'h1)
		|-> !pulseLvl[0])
		else $error("stop low not low");
	shot_idle_a: assert property (@(posedge clk) disable iff (srst)
		shotDone[0] |=> cfg_r[0][`CFG_MODE_LSB +: 3] == 3'h0)
		else $error("one-shot did not return to idle");
	run_wave_a: assert property (@(posedge clk) disable iff (srst)
		(cfg_r[0][`CFG_GEN_LSB +: 2] == 2'h1
		&& cfg_r[0][`CFG_MODE_LSB +: 3] == 3'h3) |-> pulseLvl[0] == wave[0])
		else $error("run mode not following generator");
	none_gen_a: assert property (@(posedge clk) disable iff (srst)
		cfg_r[0][`CFG_GEN_LSB +: 2] == 2'h0 |-> (pulseLvl[0]
		== cfg_r[0][`CFG_LVL_BIT] && !shotDone[0]))
		else $error("pulse active with no generator");
	idle_quiet_a: assert property (@(posedge clk) disable iff (srst)
		(pulseOn[0] && cfg_r[0][`CFG_MODE_LSB +: 3] == 3'h0)
		|-> pulseLvl[0] == cfg_r[0][`CFG_LVL_BIT])
		else $error("idle mode toggled");
	apb_ready_a: assert property (@(posedge clk) disable iff (srst)
		(psel && !penable) |=> pready ##1 !pready)
		else $error("apb ready timing");
	tri_release_a: assert property (@(posedge clk) disable iff (srst)
		(cfg_r[0][`CFG_SEL_BIT] && cfg_r[0][`CFG_DIR_BIT]
		&& cfg_r[0][`CFG_TYPE_LSB +: 2] == 2'h2) |=> !pinOe[0])
		else $error("tri-state pin driven");
	pin_keep_a: assert property (@(posedge clk) disable iff (srst)
		(wrEn && cfgHit && cfgIdx != 12'h000 && !shotDone[0])
		|=> cfg_r[0] == $past(cfg_r[0]))
		else $error("other pin write changed pin 0");
	serial_status_a: assert property (@(posedge clk) disable iff (srst)
		(rdEn && paddr == `PINSTAT_OFF && !cfg_r[0][`CFG_SEL_BIT])
		|-> !prdata[0])
		else $error("serial pin shown in status");
	shot_flip_a: assert property (@(posedge clk) disable iff (srst)
		(shotArm_r[0] && !shotDone[0] && pulseOn[0]
		&& cfg_r[0][`CFG_MODE_LSB +: 3] == 3'h2)
		|-> pulseLvl[0] != shotLvl_r[0])
		else $error("one-shot level not inverted");
	unmapped_err_a: assert property (@(posedge clk) disable iff (srst)
		(psel && !penable && rdErr) |=> (pslverr && prdata == 32'h0000_0000))
		else $error("unmapped access not refused");

	shot_cov: cover property (@(posedge clk) disable iff (srst) shotDone[0]);
	run_cov: cover property (@(posedge clk) disable iff (srst)
		pulseOn[0] && cfg_r[0][`CFG_MODE_LSB +: 3] == 3'h3 && pinOut[0]);
	err_cov: cover property (@(posedge clk) disable iff (srst) pslverr);
	stop_cov: cover property (@(posedge clk) disable iff (srst)
		pulseOn[0] && cfg_r[0][`CFG_MODE_LSB +: 3] == 3'h4 && pinOut[0]);
	input_cov: cover property (@(posedge clk) disable iff (srst)
		cfg_r[0][`CFG_SEL_BIT] && !cfg_r[0][`CFG_DIR_BIT] && !pinOe[0]);

endmodule

// [verilog/gpio_pwm_regs.svh]
`ifndef GPIO_PWM_REGS_SVH
`define GPIO_PWM_REGS_SVH

`define PINCFG_BASE     12'h000
`define PINSTAT_OFF     12'h100
`define PWMPER0_OFF     12'h104
`define PWMPER1_OFF     12'h108
`define PWMLOW0_OFF     12'h10C
`define PWMLOW1_OFF     12'h110

`define CFG_SEL_BIT     0
`define CFG_DIR_BIT     1
`define CFG_TYPE_LSB    2
`define CFG_LVL_BIT     4
`define CFG_MODE_LSB    5
`define CFG_GEN_LSB     8
`define CFG_WIDTH       10

`define CFG_RESET       10'h000
`define PER_RESET       16'h0063
`define LOW_RESET       16'h0031

`endif

// [verilog/gpio_pwm_pkg.sv]
package gpio_pwm_pkg;

	typedef enum logic [1:0] {
		DRV_PUSHPULL  = 2'h0,
		DRV_OPENDRAIN = 2'h1,
		DRV_TRISTATE  = 2'h2
	} drive_e;

	typedef enum logic [2:0] {
		PM_IDLE     = 3'h0,
		PM_STOPLOW  = 3'h1,
		PM_ONESHOT  = 3'h2,
		PM_RUN      = 3'h3,
		PM_STOPHIGH = 3'h4
	} pulse_mode_e;

	typedef enum logic [1:0] {
		GEN_NONE = 2'h0,
		GEN_A    = 2'h1,
		GEN_B    = 2'h2
	} gen_sel_e;

endpackage

// [verilog/pulse_gen.sv]
`timescale 1ns/1ns
`include "gpio_pwm_regs.svh"

// shared pulse generator: free-running period counter
module pulse_gen
	import gpio_pwm_pkg::*;
#(
	parameter int CW = 16
) (
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire logic [CW-1:0] period,
	input  wire logic [CW-1:0] lowTime,
	output logic               wave,
	output logic               periodEnd
);

	logic [CW-1:0] count_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			count_r <= '0;
		end else if (count_r >= period) begin
			count_r <= '0;
		end else begin
			count_r <= count_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wave      <= 1'b0;
			periodEnd <= 1'b0;
		end else begin
			wave      <= (count_r >= lowTime);
			periodEnd <= (count_r >= period);
		end
	end

endmodule

// [dv/pin_load_model.sv]
`timescale 1ns/1ns

// far-side load: pull-up on every released pin, optional external driver
module pin_load_model #(
	parameter int N = 8
) (
	input  wire logic [N-1:0] pinOut,
	input  wire logic [N-1:0] pinOe,
	input  wire logic [N-1:0] extVal,
	input  wire logic [N-1:0] extEn,
	output logic      [N-1:0] level
);
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (pinOe[i])
				level[i] = pinOut[i];
			else if (extEn[i])
				level[i] = extVal[i];
			else
				level[i] = 1'b1;
		end
	end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ns

module tb_top;
	import gpio_pwm_pkg::*;
	logic        clk = 0;
	logic        srst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  level;
	logic [7:0]  pinOut;
	logic [7:0]  pinOe;
	logic [7:0]  gpioOwned;
	logic [7:0]  serialIn;
	logic [7:0]  serialOut = 8'h00;
	logic [7:0]  serialOe = 8'h00;
	logic [7:0]  extVal = 8'h00;
	logic [7:0]  extEn = 8'h00;
	int          num_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	logic [31:0] rd;
	logic        er;
	int          tg;
	logic        lastLvl;

	always #5 clk = ~clk;

	gpio_pin_pwm_control gpio_pin_pwm_control_inst (.clk(clk), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pinIn(level), .pinOut(pinOut), .pinOe(pinOe),
		.gpioOwned(gpioOwned), .serialOut(serialOut),
		.serialOe(serialOe), .serialIn(serialIn));
	pin_load_model pin_load_model_inst (.pinOut(pinOut), .pinOe(pinOe),
		.extVal(extVal), .extEn(extEn), .level(level));

	task automatic report_and_stop;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [31:0] cw(logic dir, drive_e t, logic lv,
		pulse_mode_e m, gen_sel_e g);
		return {22'h0, g, m, lv, t, dir, 1'b1};
	endfunction

	task automatic watch(input int p, input int n);
		logic prev;
		tg = 0;
		prev = level[p];
		repeat (n) begin
			@(posedge clk);
			if (level[p] !== prev)
				tg++;
			prev = level[p];
		end
		lastLvl = prev;
	endtask

	drive_e      dt[4] = '{DRV_PUSHPULL, DRV_OPENDRAIN, DRV_OPENDRAIN,
		DRV_TRISTATE};
	logic        dl[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	logic        eo[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	logic        el[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
	pulse_mode_e pm[6] = '{PM_RUN, PM_RUN, PM_IDLE, PM_STOPLOW,
		PM_STOPHIGH, PM_RUN};
	gen_sel_e    pg[6] = '{GEN_A, GEN_NONE, GEN_A, GEN_A, GEN_A, GEN_B};
	logic        pl[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	logic        pt[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	logic        pe[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

	initial begin
		cyc(2);
		srst <= 1'b0;
		cyc(1);
		chk(pinOe, 0);
		chk(gpioOwned, 0);
		serialOe <= 8'h21;
		serialOut <= 8'h01;
		extEn <= 8'h10;
		cyc(4);
		chk(level[5], 0);
		chk(pinOut, 8'h01);
		chk(serialIn[4], 0);
		apb(0, 12'h100, 0);
		chk(rd, 0);
		apb(1, 12'h014, cw(1, DRV_PUSHPULL, 1, PM_IDLE, GEN_NONE));
		cyc(3);
		chk(level[5], 1);
		chk(gpioOwned, 8'h20);
		$display("test ownership done");
		apb(1, 12'h000, cw(0, DRV_PUSHPULL, 0, PM_IDLE, GEN_NONE));
		for (int v = 0; v < 2; v++) begin
			extEn <= 8'h11;
			extVal <= 8'(v);
			cyc(5);
			apb(0, 12'h100, 0);
			chk(rd[0], v[0]);
			chk(pinOe[0], 0);
		end
		extEn <= 8'h10;
		$display("test input done");
		for (int i = 0; i < 4; i++) begin
			apb(1, 12'h000, cw(1, dt[i], dl[i], PM_IDLE, GEN_NONE));
			cyc(3);
			chk(pinOe[0], eo[i]);
			chk(level[0], el[i]);
		end
		$display("test drive done");
		apb(1, 12'h104, 3);
		apb(1, 12'h108, 3);
		apb(1, 12'h10C, 1);
		apb(1, 12'h110, 1);
		apb(0, 12'h108, 0);
		chk(rd, 32'h0000_0003);
		apb(0, 12'h10C, 0);
		chk(rd, 32'h0000_0001);
		for (int i = 0; i < 6; i++) begin
			apb(1, 12'h000, cw(1, DRV_PUSHPULL, pl[i], pm[i], pg[i]));
			cyc(3);
			watch(0, 16);
			chk(tg >= 4, pt[i]);
			if (!pt[i])
				chk(lastLvl, pe[i]);
		end
		$display("test pulse modes done");
		for (int v = 0; v < 2; v++) begin
			apb(1, 12'h000, cw(1, DRV_PUSHPULL, v[0], PM_IDLE, GEN_A));
			cyc(3);
			apb(1, 12'h000, cw(1, DRV_PUSHPULL, v[0], PM_ONESHOT, GEN_A));
			watch(0, 24);
			chk(tg, 2);
			chk(lastLvl, v[0]);
			apb(0, 12'h000, 0);
			chk(rd, cw(1, DRV_PUSHPULL, v[0], PM_IDLE, GEN_A));
		end
		$display("test single pulse done");
		apb(0, 12'h200, 0);
		chk(er, 1);
		chk(rd, 0);
		chk(gpioOwned, 8'h21);
		chk(level[5], 1);
		$display("test unmapped done");
		report_and_stop;
	end
endmodule
